// File: hdl/ledfc_top.sv
// led string fault control with ahb-lite register slave
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - enable low puts every function in shutdown, standby supply only; lowest string selection and latched fault output stay active
// - critical failure forces the same shutdown as enable low; the code ignores it during the scan state
// - overvoltage trip holds boost switch off until hysteresis clear
// - string sources switch at dimming rates up to 25kHz
// - scan at enable: grounded strings disabled, others pulled up and enabled
// - in-use mask fixed after enable
// - only in-use strings feed lowest string voltage selection
// - open/short checks only after startup; failed string disabled alone
// - no open/short check for dimming on-periods under 2us
// - short when feedback above 8V and some in-use string near minimum
// - short detection inhibited during soft-start
// - in-use string below 180mV is open and disabled
// - all in-use strings open shuts boost down
// - fault output low on thermal, overvoltage or overcurrent
// - thermal latches at once, overcurrent after timer, overvoltage never
// - sources follow dimming input frequency and duty directly
// - over-temperature shuts boost and sources, fault output low
// - after thermal shutdown stay off until new enable
// - pull-up scan of 1ms; strings still low recorded unused
// - overcurrent latches only if present when 128us timer expires
module ledfc_top #(
  parameter int SCAN_CYC = ledfc_pkg::SCAN_CYC,
  parameter int SOFT_CYC = ledfc_pkg::SOFT_CYC,
  parameter int SETTLE_CYC = ledfc_pkg::SETTLE_CYC,
  parameter int OCP_CYC = ledfc_pkg::OCP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ledfc_pkg::ledfc_cmp_t cmp_in,
  output logic main_ldo_en,
  output logic boost_en,
  output logic boost_switch_en,
  output logic fb_pullup_en,
  output logic [5:0] source_en,
  output logic [5:0] lowest_string_voltage_sel,
  output logic fault_flag_output_n
);
  localparam int N = ledfc_pkg::NSTR;
  ledfc_pkg::ledfc_cmp_t s1_q, s_q;
  ledfc_pkg::ledfc_state_t st_q;
  logic en_prev_q, ovp_hold_q, otp_lat_q, ocp_lat_q, all_open_q, chk_q;
  logic [ledfc_pkg::CNT_W-1:0] cnt_q;
  logic [ledfc_pkg::CNT_W-1:0] ocp_cnt_q;
  logic [ledfc_pkg::ON_W-1:0] on_cnt_q;
  logic [N-1:0] in_use_q, dis_q, open_q, short_q;
  logic [1:0] ctrl_q;
  logic wr_q;
  logic [7:0] wa_q;
  logic [N-1:0] live, open_hit, short_hit;
  logic en_rise, crit;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0000_0000;
    case (a)
      ledfc_pkg::OFS_CTRL: rd_word[1:0] = ctrl_q;
      ledfc_pkg::OFS_STATUS: begin
        rd_word[5:0] = st_q;
        rd_word[ledfc_pkg::ST_INUSE_POS +: N] = in_use_q;
        rd_word[ledfc_pkg::ST_DIS_POS +: N] = dis_q;
        rd_word[ledfc_pkg::ST_FAULT_POS +: 4] = {all_open_q, ovp_hold_q, ocp_lat_q, otp_lat_q};
      end
      ledfc_pkg::OFS_FLAGS: begin
        rd_word[N-1:0] = open_q;
        rd_word[ledfc_pkg::FL_SHORT_POS +: N] = short_q;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  endfunction : rd_word

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s_q <= '0;
    end else begin
      s1_q <= cmp_in;
      s_q <= s1_q;
    end
  end

  assign en_rise = s_q.en && !en_prev_q;
  assign live = in_use_q & ~dis_q;
  assign crit = (s_q.otp && st_q != ledfc_pkg::st_shut) || (ocp_cnt_q == OCP_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1 && s_q.ocp);
  assign open_hit = chk_q && ctrl_q[ledfc_pkg::CTRL_OPEN_BIT] ? (s_q.open & live) : '0;
  assign short_hit = (chk_q && ctrl_q[ledfc_pkg::CTRL_SHORT_BIT] && |(s_q.near_min & live)) ? (s_q.high & live) : '0;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= s_q.en;
    end
  end

  // sequencer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= ledfc_pkg::st_shut;
      cnt_q <= '0;
    end else if (!s_q.en) begin
      st_q <= ledfc_pkg::st_shut;
      cnt_q <= '0;
    end else if (en_rise) begin
      st_q <= ledfc_pkg::st_scan;
      cnt_q <= '0;
    end else begin
      case (st_q)
        ledfc_pkg::st_scan: begin
          if (cnt_q == SCAN_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
            st_q <= ledfc_pkg::st_soft;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ledfc_pkg::st_soft: begin
          if (crit) begin
            st_q <= ledfc_pkg::st_latch;
          end else if (cnt_q == SOFT_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
            st_q <= ledfc_pkg::st_settle;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ledfc_pkg::st_settle: begin
          if (crit) begin
            st_q <= ledfc_pkg::st_latch;
          end else if (cnt_q == SETTLE_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
            st_q <= ledfc_pkg::st_run;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ledfc_pkg::st_run: begin
          if (crit || (live & ~open_hit) == '0) begin
            st_q <= ledfc_pkg::st_latch;
          end
        end
        ledfc_pkg::st_latch: st_q <= ledfc_pkg::st_latch;
        default: st_q <= ledfc_pkg::st_shut;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      in_use_q <= '0;
    end else if (en_rise) begin
      in_use_q <= '0;
    end else if (st_q == ledfc_pkg::st_scan && cnt_q == SCAN_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
      in_use_q <= ~s_q.grounded;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      on_cnt_q <= '0;
      chk_q <= 1'b0;
    end else if (!s_q.pwm || st_q != ledfc_pkg::st_run) begin
      on_cnt_q <= '0;
      chk_q <= 1'b0;
    end else begin
      if (on_cnt_q != ledfc_pkg::MIN_ON_CYC[ledfc_pkg::ON_W-1:0]) begin
        on_cnt_q <= on_cnt_q + 1'b1;
      end
      chk_q <= on_cnt_q == ledfc_pkg::MIN_ON_CYC[ledfc_pkg::ON_W-1:0] - 1'b1 || chk_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || en_rise) begin
      dis_q <= '0;
      open_q <= '0;
      short_q <= '0;
    end else if (st_q == ledfc_pkg::st_run) begin
      dis_q <= dis_q | open_hit | short_hit;
      open_q <= open_q | open_hit;
      short_q <= short_q | short_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || en_rise) begin
      otp_lat_q <= 1'b0;
      ocp_lat_q <= 1'b0;
      all_open_q <= 1'b0;
    end else if (st_q != ledfc_pkg::st_shut && st_q != ledfc_pkg::st_scan) begin
      if (s_q.otp) begin
        otp_lat_q <= 1'b1;
      end
      if (s_q.ocp && ocp_cnt_q == OCP_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
        ocp_lat_q <= 1'b1;
      end
      if (st_q == ledfc_pkg::st_run && (live & ~open_hit) == '0) begin
        all_open_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !s_q.ocp || en_rise) begin
      ocp_cnt_q <= '0;
    end else if (ocp_cnt_q != OCP_CYC[ledfc_pkg::CNT_W-1:0] - 1'b1) begin
      ocp_cnt_q <= ocp_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ovp_hold_q <= 1'b0;
    end else if (s_q.ovp_trip) begin
      ovp_hold_q <= 1'b1;
    end else if (s_q.ovp_clear) begin
      ovp_hold_q <= 1'b0;
    end
  end

  // outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      main_ldo_en <= 1'b0;
      boost_en <= 1'b0;
      boost_switch_en <= 1'b0;
      fb_pullup_en <= 1'b0;
      source_en <= '0;
      lowest_string_voltage_sel <= '0;
      fault_flag_output_n <= 1'b1;
    end else begin
      main_ldo_en <= st_q != ledfc_pkg::st_shut && st_q != ledfc_pkg::st_latch;
      boost_en <= st_q == ledfc_pkg::st_soft || st_q == ledfc_pkg::st_settle || st_q == ledfc_pkg::st_run;
      boost_switch_en <= (st_q == ledfc_pkg::st_soft || st_q == ledfc_pkg::st_settle || st_q == ledfc_pkg::st_run)
                         && !s_q.ovp_trip && !ovp_hold_q;
      fb_pullup_en <= st_q == ledfc_pkg::st_scan;
      source_en <= (st_q == ledfc_pkg::st_soft || st_q == ledfc_pkg::st_settle || st_q == ledfc_pkg::st_run)
                   && s_q.pwm ? live : '0;
      lowest_string_voltage_sel <= live;
      fault_flag_output_n <= !(otp_lat_q || ocp_lat_q || (ovp_hold_q && st_q != ledfc_pkg::st_shut));
    end
  end

  // ahb-lite slave, zero wait states
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
      wa_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata <= haddr[31:8] == 24'h00_0000 ? rd_word(haddr[7:0]) : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_q <= ledfc_pkg::CTRL_RST;
    end else if (wr_q && wa_q == ledfc_pkg::OFS_CTRL) begin
      ctrl_q <= hwdata[1:0];
    end
  end

  property p_shut_on_disable;
    @(posedge clk) disable iff (!reset_n) !s_q.en |=> st_q == ledfc_pkg::st_shut ##1 !main_ldo_en && !boost_en;
  endproperty
  a_shut_on_disable: assert property (p_shut_on_disable) else $error("enable low did not shut down");

  property p_crit_shut;
    @(posedge clk) disable iff (!reset_n) (crit && s_q.en && !en_rise && st_q != ledfc_pkg::st_scan)
      |=> st_q == ledfc_pkg::st_latch ##1 !main_ldo_en;
  endproperty
  a_crit_shut: assert property (p_crit_shut) else $error("critical fault did not shut down");

  property p_ovp_gate;
    @(posedge clk) disable iff (!reset_n) s_q.ovp_trip ##1 !s_q.ovp_clear |=> !boost_switch_en [*2];
  endproperty
  a_ovp_gate: assert property (p_ovp_gate) else $error("boost switched during overvoltage");

  property p_mask_fixed;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_run && s_q.en |=> $stable(in_use_q);
  endproperty
  a_mask_fixed: assert property (p_mask_fixed) else $error("string mask changed after enable");

  property p_short_soft;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_soft && !en_rise |=> $stable(short_q);
  endproperty
  a_short_soft: assert property (p_short_soft) else $error("short flagged during soft-start");

  property p_open_dis;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_run && !en_rise && |open_hit
      |=> (dis_q & $past(open_hit)) == $past(open_hit);
  endproperty
  a_open_dis: assert property (p_open_dis) else $error("open string not disabled");

  property p_fault_pin;
    @(posedge clk) disable iff (!reset_n) s_q.otp && s_q.en && !en_rise && st_q != ledfc_pkg::st_shut
      && st_q != ledfc_pkg::st_scan |=> ##1 !fault_flag_output_n;
  endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault output not low on thermal fault");

  property p_dim_follow;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_run |=> source_en == ($past(s_q.pwm) ? $past(live) : '0);
  endproperty
  a_dim_follow: assert property (p_dim_follow) else $error("sources do not follow dimming input");

  property p_latch_hold;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_latch && s_q.en && !en_rise |=> st_q == ledfc_pkg::st_latch;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("left latch without new enable");

  property p_ocp_timer;
    @(posedge clk) disable iff (!reset_n) $rose(ocp_lat_q) |-> $past(ocp_cnt_q) == OCP_CYC - 1 && $past(s_q.ocp);
  endproperty
  a_ocp_timer: assert property (p_ocp_timer) else $error("overcurrent latched before timer");

  property p_min_on;
    @(posedge clk) disable iff (!reset_n) |(open_hit | short_hit) |-> on_cnt_q == ledfc_pkg::MIN_ON_CYC;
  endproperty
  a_min_on: assert property (p_min_on) else $error("check ran in short on-period");

  property p_pullup_scan;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_scan |=> fb_pullup_en;
  endproperty
  a_pullup_scan: assert property (p_pullup_scan) else $error("pull-ups off during scan");

  property p_all_open;
    @(posedge clk) disable iff (!reset_n) st_q == ledfc_pkg::st_run && s_q.en && (live & ~open_hit) == '0
      |=> st_q == ledfc_pkg::st_latch ##1 !boost_en;
  endproperty
  a_all_open: assert property (p_all_open) else $error("boost kept running with all strings open");

  property p_sel_live;
    @(posedge clk) disable iff (!reset_n) s_q.en |=> lowest_string_voltage_sel == $past(live);
  endproperty
  a_sel_live: assert property (p_sel_live) else $error("selection includes unused strings");
endmodule : ledfc_top

// File: inc/ledfc_pkg.sv
// constants, types and register map of the led string fault control block
package ledfc_pkg;
  localparam int CLK_MHZ = 50;
  localparam int T_SCAN_US = 1000;
  localparam int T_SOFT_US = 2000;
  localparam int T_SETTLE_US = 1000;
  localparam int T_OCP_US = 128;
  localparam int T_MIN_ON_NS = 2000;
  localparam int SCAN_CYC = T_SCAN_US * CLK_MHZ;
  localparam int SOFT_CYC = T_SOFT_US * CLK_MHZ;
  localparam int SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
  localparam int OCP_CYC = T_OCP_US * CLK_MHZ;
  localparam int MIN_ON_CYC = (T_MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 17;
  localparam int ON_W = 8;
  localparam int NSTR = 6;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int CTRL_OPEN_BIT = 0;
  localparam int CTRL_SHORT_BIT = 1;
  localparam int ST_INUSE_POS = 8;
  localparam int ST_DIS_POS = 16;
  localparam int ST_FAULT_POS = 24;
  localparam int FL_SHORT_POS = 8;

  typedef enum logic [5:0] {
    st_shut = 6'h01,
    st_scan = 6'h02,
    st_soft = 6'h04,
    st_settle = 6'h08,
    st_run = 6'h10,
    st_latch = 6'h20
  } ledfc_state_t;

  typedef struct packed {
    logic en;
    logic pwm;
    logic ovp_trip;
    logic ovp_clear;
    logic ocp;
    logic otp;
    logic [5:0] grounded;
    logic [5:0] open;
    logic [5:0] high;
    logic [5:0] near_min;
  } ledfc_cmp_t;
endpackage : ledfc_pkg

// File: testbench/ledfc_partner.sv
// behavioural model of the led strings, comparators and host signals
`timescale 1ns/1ps
module ledfc_partner (
  input wire logic en,
  input wire logic pwm,
  input wire logic ovp_trip,
  input wire logic ovp_clear,
  input wire logic ocp,
  input wire logic otp,
  input wire logic [5:0][1:0] kind,
  input wire logic fb_pullup_en,
  input wire logic [5:0] source_en,
  output ledfc_pkg::ledfc_cmp_t cmp_out
);
  // kind per string: 0 healthy, 1 tied to ground, 2 open, 3 shorted leds
  always_comb begin
    cmp_out.en = en;
    cmp_out.pwm = pwm;
    cmp_out.ovp_trip = ovp_trip;
    cmp_out.ovp_clear = ovp_clear;
    cmp_out.ocp = ocp;
    cmp_out.otp = otp;
    for (int i = 0; i < 6; i++) begin
      // grounded pin stays low even against the scan pull-up
      cmp_out.grounded[i] = (kind[i] == 2'd1);
      cmp_out.open[i] = (kind[i] == 2'd1) || ((kind[i] == 2'd2) && source_en[i] && !fb_pullup_en);
      cmp_out.high[i] = (kind[i] == 2'd3) && source_en[i];
      cmp_out.near_min[i] = (kind[i] == 2'd0) && source_en[i];
    end
  end
endmodule : ledfc_partner

// File: testbench/ledfc_top_tb.sv
// self-checking bench of the led string fault control block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module ledfc_top_tb;
  typedef struct packed {
    logic pwm;
    logic trip;
    logic clr;
    logic [5:0] src;
    logic sw;
    logic flt_n;
  } ledfc_row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout, hresp, main_ldo_en, boost_en, boost_switch_en, fb_pullup_en, fault_n;
  logic [31:0] hrdata;
  logic [5:0] source_en, low_sel;
  logic en = 1'b0, pwm = 1'b0, trip = 1'b0, clr = 1'b1, ocp = 1'b0, otp = 1'b0;
  logic [5:0][1:0] kind = '0;
  ledfc_pkg::ledfc_cmp_t cmp;
  logic [31:0] rd;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  ledfc_row_t rows [5] = '{
    '{1'b1, 1'b0, 1'b1, 6'h1f, 1'b1, 1'b1}, '{1'b0, 1'b0, 1'b1, 6'h00, 1'b1, 1'b1},
    '{1'b1, 1'b1, 1'b0, 6'h1f, 1'b0, 1'b0}, '{1'b1, 1'b0, 1'b0, 6'h1f, 1'b0, 1'b0},
    '{1'b1, 1'b0, 1'b1, 6'h1f, 1'b1, 1'b1}};

  assign hready = hreadyout;
  always #10 clk = ~clk;

  ledfc_top #(.SCAN_CYC(20), .SOFT_CYC(40), .SETTLE_CYC(20), .OCP_CYC(10)) ledfc_top_inst (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .cmp_in(cmp), .main_ldo_en(main_ldo_en), .boost_en(boost_en),
    .boost_switch_en(boost_switch_en), .fb_pullup_en(fb_pullup_en), .source_en(source_en),
    .lowest_string_voltage_sel(low_sel), .fault_flag_output_n(fault_n));

  ledfc_partner ledfc_partner_inst (
    .en(en), .pwm(pwm), .ovp_trip(trip), .ovp_clear(clr), .ocp(ocp), .otp(otp), .kind(kind),
    .fb_pullup_en(fb_pullup_en), .source_en(source_en), .cmp_out(cmp));

  task complete_run;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // single word transfer, waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task wait_state(input logic [5:0] s);
    for (int i = 0; i < 300; i++) begin
      ahb(1'b0, ledfc_pkg::OFS_STATUS, 32'h0000_0000);
      if (rd[5:0] === s) break;
    end
  endtask : wait_state

  task restart;
    @(posedge clk);
    en <= 1'b0;
    repeat (6) @(posedge clk);
    en <= 1'b1;
    wait_state(6'h10);
  endtask : restart

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(main_ldo_en, 1'b0)
    `CHK(fault_n, 1'b1)
    ahb(1'b0, ledfc_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    `CHK(hresp, 1'b0)
    ahb(1'b1, ledfc_pkg::OFS_CTRL, 32'h0000_0000);
    ahb(1'b0, ledfc_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    ahb(1'b1, ledfc_pkg::OFS_CTRL, 32'h0000_0003);
    ahb(1'b0, ledfc_pkg::OFS_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0003)
    ahb(1'b0, 8'h0c, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    ahb(1'b1, ledfc_pkg::OFS_STATUS, 32'hffff_ffff);
    ahb(1'b0, ledfc_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK(rd[5:0], 6'h01)
    // string 5 unused, string 2 shorted while the boost soft-starts
    kind[5] <= 2'd1;
    kind[2] <= 2'd3;
    pwm <= 1'b1;
    en <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(fb_pullup_en, 1'b1)
    wait_state(6'h04);
    `CHK(rd[13:8], 6'h1f)
    `CHK(fb_pullup_en, 1'b0)
    `CHK(main_ldo_en, 1'b1)
    wait_state(6'h08);
    ahb(1'b0, ledfc_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    kind[2] <= 2'd0;
    wait_state(6'h10);
    `CHK(low_sel, 6'h1f)
    foreach (rows[i]) begin
      @(posedge clk);
      pwm <= rows[i].pwm;
      trip <= rows[i].trip;
      clr <= rows[i].clr;
      repeat (4) @(posedge clk);
      `CHK(source_en, rows[i].src)
      repeat (4) @(posedge clk);
      `CHK(source_en, rows[i].src)
      `CHK(boost_switch_en, rows[i].sw)
      `CHK(fault_n, rows[i].flt_n)
    end
    // grounding after enable leaves the mask alone
    pwm <= 1'b0;
    kind[0] <= 2'd1;
    repeat (6) @(posedge clk);
    ahb(1'b0, ledfc_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK({rd[21:16], rd[13:8]}, 12'h01f)
    kind[0] <= 2'd0;
    kind[1] <= 2'd2;
    pwm <= 1'b1;
    repeat (50) @(posedge clk);
    pwm <= 1'b0;
    repeat (6) @(posedge clk);
    ahb(1'b0, ledfc_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    @(posedge clk);
    pwm <= 1'b1;
    repeat (150) @(posedge clk);
    ahb(1'b0, ledfc_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(rd[5:0], 6'h02)
    `CHK(source_en, 6'h1d)
    kind[3] <= 2'd3;
    repeat (150) @(posedge clk);
    ahb(1'b0, ledfc_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(rd[13:8], 6'h08)
    `CHK(source_en, 6'h15)
    // remaining live strings all open
    kind <= {2'd1, 2'd0, 2'd0, 2'd0, 2'd0, 2'd0} | 12'h222;
    repeat (150) @(posedge clk);
    `CHK(boost_en, 1'b0)
    kind <= {2'd1, 10'h000};
    restart();
    ahb(1'b0, ledfc_pkg::OFS_FLAGS, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    `CHK(source_en, 6'h1f)
    // short overcurrent pulse must not latch
    ocp <= 1'b1;
    repeat (5) @(posedge clk);
    ocp <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(boost_en, 1'b1)
    ocp <= 1'b1;
    repeat (20) @(posedge clk);
    ocp <= 1'b0;
    `CHK(fault_n, 1'b0)
    `CHK(boost_en, 1'b0)
    `CHK(source_en, 6'h00)
    en <= 1'b0;
    repeat (6) @(posedge clk);
    `CHK(main_ldo_en, 1'b0)
    `CHK(boost_switch_en, 1'b0)
    restart();
    otp <= 1'b1;
    repeat (6) @(posedge clk);
    otp <= 1'b0;
    `CHK(fault_n, 1'b0)
    `CHK(source_en, 6'h00)
    `CHK(boost_switch_en, 1'b0)
    repeat (10) @(posedge clk);
    `CHK(boost_en, 1'b0)
    `CHK(fault_n, 1'b0)
    complete_run();
  end
endmodule : ledfc_top_tb
